// *** rtl/press_pkg.sv ***
// shared constants and types for the press contact sequence monitor
// assumes a single 200 MHz logic clock; all times are counted in that clock
package press_pkg;
  // clock period and the 1 ms tick that restart pulses are timed with
  localparam int unsigned CLOCK_PERIOD_NS = 32'h0000_0005;
  localparam int unsigned TICK_PERIOD_NS  = 32'h000F_4240;
  localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLOCK_PERIOD_NS;

  // restart pulse limits in milliseconds (one tick = 1 ms)
  localparam logic [15:0] MIN_PULSE_SHORT_MS = 16'h0064;
  localparam logic [15:0] MIN_PULSE_LONG_MS  = 16'h015E;
  localparam logic [15:0] MAX_PULSE_MS       = 16'h7530;

  // bottom contact rising edges allowed per cycle
  localparam logic [1:0] SINGLE_RAMP_COUNT = 2'h1;
  localparam logic [1:0] MULTI_RAMP_LIMIT  = 2'h2;

  // monitoring phase; reset value is phase_init
  typedef enum logic [2:0] {
    PH_INIT = 3'b001,
    PH_SYNC = 3'b010,
    PH_RUN  = 3'b100
  } phase_t;
  localparam phase_t PHASE_RESET = PH_INIT;
endpackage

// *** rtl/restart_pulse_timer.sv ***
// restart pulse timer: qualifies a low-high-low pulse by its high time
// assumes restart_i is synchronous to clock_i; one-cycle valid_o at the fall
`timescale 1ns/1ps
module restart_pulse_timer #(
  parameter int unsigned TICK_CYCLES     = press_pkg::TICK_CYCLES,
  parameter logic [15:0] MIN_SHORT_TICKS = press_pkg::MIN_PULSE_SHORT_MS,
  parameter logic [15:0] MIN_LONG_TICKS  = press_pkg::MIN_PULSE_LONG_MS,
  parameter logic [15:0] MAX_TICKS       = press_pkg::MAX_PULSE_MS
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic restart_i,
  input  wire logic long_min_i,
  output logic      valid_o
);
  typedef struct packed {
    logic        prev;
    logic [31:0] prescale;
    logic [15:0] ticks;
    logic        valid;
  } timer_t;

  timer_t      st;
  timer_t      next_st;
  logic [15:0] min_ticks;

  assign min_ticks = long_min_i ? MIN_LONG_TICKS : MIN_SHORT_TICKS;

  // count whole ticks of high time; saturate at the upper limit so a stuck input cannot wrap
  always_comb begin
    next_st       = st;
    next_st.prev  = restart_i;
    next_st.valid = 1'b0;
    if (restart_i && !st.prev) begin
      next_st.prescale = 32'h0000_0000;
      next_st.ticks    = 16'h0000;
    end else if (restart_i) begin
      if (st.prescale == 32'(TICK_CYCLES - 1)) begin // RL22
        next_st.prescale = 32'h0000_0000;
        if (st.ticks < MAX_TICKS) begin
          next_st.ticks = st.ticks + 16'h0001;
        end
      end else begin
        next_st.prescale = st.prescale + 32'h0000_0001;
      end
    end else if (st.prev) begin
      next_st.valid = (st.ticks >= min_ticks) && (st.ticks < MAX_TICKS); // RL2 RL3
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign valid_o = st.valid;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_short_ignored;
    $fell(restart_i) && (st.ticks < min_ticks) |=> !valid_o;
  endproperty
  a_short_ignored: assert property (p_short_ignored) else $error("short restart pulse accepted"); // RL3

  property p_long_ignored;
    $fell(restart_i) && (st.ticks >= MAX_TICKS) |=> !valid_o;
  endproperty
  a_long_ignored: assert property (p_long_ignored) else $error("overlong restart pulse accepted"); // RL3

  property p_valid_window;
    valid_o |-> $past(st.ticks) >= ($past(long_min_i) ? MIN_LONG_TICKS : MIN_SHORT_TICKS);
  endproperty
  a_valid_window: assert property (p_valid_window) else $error("restart accepted below minimum"); // RL2

  property p_tick_count;
    restart_i && st.prev && (st.prescale == 32'(TICK_CYCLES - 1)) && (st.ticks < MAX_TICKS)
      |=> st.ticks == $past(st.ticks) + 16'h0001;
  endproperty
  a_tick_count: assert property (p_tick_count) else $error("tick not counted"); // RL22
endmodule

// *** rtl/press_contact_sequence_monitor.sv ***
// press contact sequence monitor: crank contact order, upstroke, faults, restart
// assumes all inputs synchronous to clock_i; configuration held static while running
//
// Function
// [RL1] restart input usable only when enabled
// [RL2] clear pulse high at least 100/350 ms
// [RL3] too short or over 30 s ignored
// [RL4] one overtravel pulse per press cycle
// [RL5] overtravel rises before top contact falls
// [RL6] overtravel falls after top contact rises
// [RL7] bottom rise with top high marks bottom
// [RL8] single mode: exactly one bottom rise
// [RL9] bad edge order sets sequence fault
// [RL10] multi mode accepts zero to two rises
// [RL11] first bottom rise raises upstroke
// [RL12] multi mode: bottom fall ends upstroke
// [RL13] bottom rises near 180 with top high
// [RL14] bottom low at every top rise
// [RL15] optional error flag mirrors any fault
// [RL16] overtravel checks only when enabled
// [RL17] reset pending while any fault latched
// [RL18] drive command must cover overtravel fall
// [RL19] stop input blanks enable, top, upstroke
// [RL20] bottom high at start: no upstroke first cycle
// [RL21] edges from one-cycle-old samples
// [RL22] restart pulse timed by tick counter
`timescale 1ns/1ps
module press_contact_sequence_monitor #(
  parameter int unsigned TICK_CYCLES     = press_pkg::TICK_CYCLES,
  parameter logic [15:0] MIN_SHORT_TICKS = press_pkg::MIN_PULSE_SHORT_MS,
  parameter logic [15:0] MIN_LONG_TICKS  = press_pkg::MIN_PULSE_LONG_MS,
  parameter logic [15:0] MAX_TICKS       = press_pkg::MAX_PULSE_MS
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic top_dead_centre_contact_i,
  input  wire logic bottom_dead_centre_contact_i,
  input  wire logic overtravel_contact_i,
  input  wire logic drive_command_i,
  input  wire logic run_permit_i,
  input  wire logic restart_i,
  input  wire logic cfg_restart_en_i,
  input  wire logic cfg_multi_ramp_i,
  input  wire logic cfg_long_min_pulse_i,
  input  wire logic cfg_error_flag_en_i,
  input  wire logic cfg_overtravel_en_i,
  output logic      press_enable_o,
  output logic      top_o,
  output logic      upstroke_o,
  output logic      reset_pending_o,
  output logic      sequence_fault_o,
  output logic      overtravel_fault_o,
  output logic      error_flag_o
);
  typedef struct packed {
    press_pkg::phase_t phase;
    logic              tdc_q;
    logic              bdc_q;
    logic              ot_q;
    logic              drv_q;
    logic [1:0]        ramp_cnt;
    logic [1:0]        ot_cnt;
    logic              armed;
    logic              drv_seen;
    logic              top;
    logic              upstroke;
    logic              seq_fault;
    logic              ot_fault;
    logic              enable;
    logic              err_flag;
  } mon_t;

  mon_t mon;
  mon_t next_mon;
  logic clear_ok;
  logic clear;
  logic tdc_rise;
  logic tdc_fall;
  logic bdc_rise;
  logic bdc_fall;
  logic ot_rise;
  logic ot_fall;
  logic seq_err;
  logic ot_err;

  restart_pulse_timer #(
    .TICK_CYCLES    (TICK_CYCLES),
    .MIN_SHORT_TICKS(MIN_SHORT_TICKS),
    .MIN_LONG_TICKS (MIN_LONG_TICKS),
    .MAX_TICKS      (MAX_TICKS)
  ) u_restart (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (restart_i),
    .long_min_i(cfg_long_min_pulse_i),
    .valid_o   (clear_ok)
  );

  // without the restart option only a full reset clears faults
  assign clear = clear_ok && cfg_restart_en_i; // RL1

  // edges against last cycle's samples
  assign tdc_rise = top_dead_centre_contact_i && !mon.tdc_q; // RL21
  assign tdc_fall = !top_dead_centre_contact_i && mon.tdc_q;
  assign bdc_rise = bottom_dead_centre_contact_i && !mon.bdc_q;
  assign bdc_fall = !bottom_dead_centre_contact_i && mon.bdc_q;
  assign ot_rise  = overtravel_contact_i && !mon.ot_q;
  assign ot_fall  = !overtravel_contact_i && mon.ot_q;

  // sequence checks; only live once a whole cycle is being tracked
  always_comb begin
    seq_err = 1'b0;
    ot_err  = 1'b0;
    if (mon.phase == press_pkg::PH_RUN && run_permit_i) begin
      if (tdc_rise && bottom_dead_centre_contact_i) begin
        seq_err = 1'b1; // RL14
      end
      if (bdc_rise && !top_dead_centre_contact_i) begin
        seq_err = 1'b1; // RL7 RL13
      end
      if (bdc_rise && !cfg_multi_ramp_i && mon.ramp_cnt >= press_pkg::SINGLE_RAMP_COUNT) begin
        seq_err = 1'b1; // RL8
      end
      if (bdc_rise && cfg_multi_ramp_i && mon.ramp_cnt >= press_pkg::MULTI_RAMP_LIMIT) begin
        seq_err = 1'b1; // RL10
      end
      if (tdc_fall && !cfg_multi_ramp_i && mon.ramp_cnt == 2'h0) begin
        seq_err = 1'b1; // RL8 RL9
      end
      if (cfg_overtravel_en_i) begin // RL16
        if (tdc_fall && !overtravel_contact_i) begin
          seq_err = 1'b1; // RL5
        end
        if (ot_fall && !top_dead_centre_contact_i) begin
          seq_err = 1'b1; // RL6
        end
        if ((ot_rise && mon.ot_cnt != 2'h0) || (tdc_fall && mon.ot_cnt == 2'h0 && !ot_rise)) begin
          seq_err = 1'b1; // RL4
        end
        if (ot_fall && !drive_command_i && !mon.drv_seen) begin
          ot_err = 1'b1; // RL18
        end
      end
    end
  end

  // next state; a new fault beats a clear arriving in the same cycle
  always_comb begin
    next_mon           = mon;
    next_mon.tdc_q     = top_dead_centre_contact_i;
    next_mon.bdc_q     = bottom_dead_centre_contact_i;
    next_mon.ot_q      = overtravel_contact_i;
    next_mon.drv_q     = drive_command_i;
    next_mon.seq_fault = (mon.seq_fault && !clear) || seq_err; // RL9
    next_mon.ot_fault  = (mon.ot_fault && !clear) || ot_err;   // RL18
    if (!run_permit_i || next_mon.seq_fault || next_mon.ot_fault) begin
      // stop or fault: outputs blanked, tracking restarts from a fresh sample later
      next_mon.phase    = press_pkg::PH_INIT; // RL19
      next_mon.top      = 1'b0;
      next_mon.upstroke = 1'b0;
    end else begin
      unique case (mon.phase)
        press_pkg::PH_INIT: begin
          // contact levels taken as found; a bottom already made spoils this cycle
          next_mon.phase    = press_pkg::PH_SYNC;
          next_mon.armed    = !bottom_dead_centre_contact_i; // RL20
          next_mon.top      = top_dead_centre_contact_i;
          next_mon.upstroke = 1'b0;
          next_mon.ramp_cnt = 2'h0;
          next_mon.ot_cnt   = 2'h0;
          next_mon.drv_seen = drive_command_i;
        end
        press_pkg::PH_SYNC, press_pkg::PH_RUN: begin
          if (tdc_rise) begin
            next_mon.phase    = press_pkg::PH_RUN;
            next_mon.top      = 1'b1;
            next_mon.ramp_cnt = 2'h0;
            next_mon.drv_seen = 1'b0;
          end
          if (drive_command_i && !mon.drv_q && mon.top) begin
            next_mon.drv_seen = 1'b1; // RL18
          end
          if (ot_rise && mon.ot_cnt != 2'h3) begin
            next_mon.ot_cnt = mon.ot_cnt + 2'h1;
          end
          if (bdc_rise && top_dead_centre_contact_i) begin
            if (mon.ramp_cnt != 2'h3) begin
              next_mon.ramp_cnt = mon.ramp_cnt + 2'h1; // RL7
            end
            if (mon.ramp_cnt == 2'h0 && mon.armed) begin
              next_mon.upstroke = 1'b1; // RL11
            end
          end
          if (bdc_fall && cfg_multi_ramp_i) begin
            next_mon.upstroke = 1'b0; // RL12
          end
          if (tdc_fall) begin
            next_mon.top      = 1'b0;
            next_mon.upstroke = 1'b0;
            next_mon.armed    = 1'b1; // RL20
            next_mon.ot_cnt   = ot_rise ? 2'h1 : 2'h0;
          end
        end
      endcase
    end
    next_mon.enable   = run_permit_i && !next_mon.seq_fault && !next_mon.ot_fault; // RL17 RL19
    next_mon.err_flag = cfg_error_flag_en_i && (next_mon.seq_fault || next_mon.ot_fault); // RL15
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mon       <= '0;
      mon.phase <= press_pkg::PHASE_RESET;
    end else begin
      mon <= next_mon;
    end
  end

  // outputs straight from flops, except reset_pending_o, the OR of the two fault flops
  assign press_enable_o     = mon.enable;
  assign top_o              = mon.top;
  assign upstroke_o         = mon.upstroke;
  assign sequence_fault_o   = mon.seq_fault;
  assign overtravel_fault_o = mon.ot_fault;
  assign reset_pending_o    = mon.seq_fault || mon.ot_fault; // RL17
  assign error_flag_o       = mon.err_flag;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_faulted;
    reset_pending_o && !cfg_restart_en_i;
  endsequence
  property p_clear_gated;
    s_faulted |=> reset_pending_o;
  endproperty
  a_clear_gated: assert property (p_clear_gated) else $error("fault cleared with restart disabled"); // RL1

  property p_upstroke_rise;
    mon.phase == press_pkg::PH_RUN && run_permit_i && bdc_rise && top_dead_centre_contact_i && !tdc_fall
      && mon.armed && mon.ramp_cnt == 2'h0 && !seq_err && !ot_err && !reset_pending_o |=> upstroke_o;
  endproperty
  a_upstroke_rise: assert property (p_upstroke_rise) else $error("upstroke missed first bottom rise"); // RL11

  property p_single_missing;
    mon.phase == press_pkg::PH_RUN && run_permit_i && !cfg_multi_ramp_i && tdc_fall && mon.ramp_cnt == 2'h0
      |=> sequence_fault_o && !press_enable_o ##1 reset_pending_o;
  endproperty
  a_single_missing: assert property (p_single_missing) else $error("missing bottom edge not flagged"); // RL8

  property p_multi_accept;
    cfg_multi_ramp_i && !cfg_overtravel_en_i && !reset_pending_o && run_permit_i && bdc_rise
      && top_dead_centre_contact_i && mon.tdc_q && mon.ramp_cnt < press_pkg::MULTI_RAMP_LIMIT |=> !sequence_fault_o;
  endproperty
  a_multi_accept: assert property (p_multi_accept) else $error("legal bottom edge flagged"); // RL10

  property p_multi_drop;
    cfg_multi_ramp_i && bdc_fall && run_permit_i |=> !upstroke_o;
  endproperty
  a_multi_drop: assert property (p_multi_drop) else $error("upstroke held past bottom fall"); // RL12

  property p_flag_mirror;
    error_flag_o |-> (sequence_fault_o || overtravel_fault_o) && $past(cfg_error_flag_en_i);
  endproperty
  a_flag_mirror: assert property (p_flag_mirror) else $error("error flag without fault"); // RL15

  property p_ot_off;
    !cfg_overtravel_en_i && !overtravel_fault_o |=> !overtravel_fault_o;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("overtravel fault while disabled"); // RL16

  property p_pending_blocks;
    reset_pending_o |-> !press_enable_o;
  endproperty
  a_pending_blocks: assert property (p_pending_blocks) else $error("enable high while reset pending"); // RL17

  property p_afterrun;
    mon.phase == press_pkg::PH_RUN && run_permit_i && cfg_overtravel_en_i && ot_fall && top_dead_centre_contact_i
      && !drive_command_i && !mon.drv_seen |=> overtravel_fault_o && !press_enable_o && reset_pending_o;
  endproperty
  a_afterrun: assert property (p_afterrun) else $error("after-run not flagged"); // RL18

  property p_stop_blank;
    !run_permit_i && !clear |=> !press_enable_o && !top_o && !upstroke_o && $stable(reset_pending_o);
  endproperty
  a_stop_blank: assert property (p_stop_blank) else $error("stop did not blank outputs"); // RL19

  property p_first_cycle;
    !mon.armed && !upstroke_o && !tdc_fall |=> !upstroke_o;
  endproperty
  a_first_cycle: assert property (p_first_cycle) else $error("upstroke raised in spoilt cycle"); // RL20
endmodule

// *** sim/press_crank_model.sv ***
// crank contact model: top, bottom and after-run contacts for one stroke per go pulse
// assumes go_i is pulsed for one clock only while busy_o is low
`timescale 1ns/1ps
module press_crank_model (
  input  wire logic       clock_i,
  input  wire logic       go_i,
  input  wire logic [1:0] n_bottom_i,
  input  wire logic       ot_en_i,
  input  wire logic [2:0] gap_i,
  output logic            top_o,
  output logic            bottom_o,
  output logic            ot_o,
  output logic            busy_o
);
  // a real crank never moves two contacts in one cycle, so every change waits a gap
  task automatic pause();
    repeat (int'(gap_i) + 2) @(posedge clock_i);
  endtask

  // one stroke: top made, after-run released, bottom pulses, after-run made, top open
  initial begin
    {top_o, bottom_o, ot_o, busy_o} <= 4'h0;
    forever begin
      @(posedge clock_i);
      if (go_i) begin
        busy_o <= 1'b1;
        top_o <= 1'b1;
        pause();
        ot_o <= 1'b0;
        for (int i = 0; i < int'(n_bottom_i); i++) begin
          pause();
          bottom_o <= 1'b1;
          pause();
          bottom_o <= 1'b0;
        end
        pause();
        ot_o <= ot_en_i | ot_o;
        pause();
        top_o <= 1'b0;
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// *** sim/press_contact_sequence_monitor_tb.sv ***
// bench for the contact monitor: strokes, sequence and after-run faults, restarts
// assumes the crank model drives the contacts; tick shortened to 4 cycles
`timescale 1ns/1ps
module press_contact_sequence_monitor_tb;
  logic        clock_i    = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        drive      = 1'b1;
  logic        permit     = 1'b1;
  logic        restart    = 1'b0;
  logic        restart_en = 1'b1;
  logic        multi      = 1'b0;
  logic        long_min   = 1'b0;
  logic        flag_en    = 1'b0;
  logic        ot_en      = 1'b1;
  logic        go         = 1'b0;
  logic [1:0]  nb         = 2'h0;
  logic [2:0]  gap        = 3'h0;
  logic [15:0] seed       = 16'h7D93;
  wire         top_c, bottom_c, ot_c, busy_c;
  wire  [6:0]  outs;
  logic [6:0]  notes[$];
  int          err_total  = 0;
  int          n_tests    = 0;

  press_crank_model i_press_crank_model (
    .clock_i    (clock_i),
    .go_i       (go),
    .n_bottom_i (nb),
    .ot_en_i    (ot_en),
    .gap_i      (gap),
    .top_o      (top_c),
    .bottom_o   (bottom_c),
    .ot_o       (ot_c),
    .busy_o     (busy_c)
  );

  press_contact_sequence_monitor #(
    .TICK_CYCLES     (4),
    .MIN_SHORT_TICKS (16'h0002),
    .MIN_LONG_TICKS  (16'h0003),
    .MAX_TICKS       (16'h000A)
  ) i_press_contact_sequence_monitor (
    .clock_i                      (clock_i),
    .sys_rst_i                    (sys_rst_i),
    .top_dead_centre_contact_i    (top_c),
    .bottom_dead_centre_contact_i (bottom_c),
    .overtravel_contact_i         (ot_c),
    .drive_command_i              (drive),
    .run_permit_i                 (permit),
    .restart_i                    (restart),
    .cfg_restart_en_i             (restart_en),
    .cfg_multi_ramp_i             (multi),
    .cfg_long_min_pulse_i         (long_min),
    .cfg_error_flag_en_i          (flag_en),
    .cfg_overtravel_en_i          (ot_en),
    .press_enable_o               (outs[6]),
    .top_o                        (outs[5]),
    .upstroke_o                   (outs[4]),
    .reset_pending_o              (outs[3]),
    .sequence_fault_o             (outs[2]),
    .overtravel_fault_o           (outs[1]),
    .error_flag_o                 (outs[0])
  );

  always #2.5 clock_i = ~clock_i;

  // notes are compared at the falling edge, when registered outputs have settled
  always @(negedge clock_i) begin
    while (notes.size() > 0) begin
      check(outs, notes.pop_front());
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // faulted outputs: enable, top and upstroke low, flag only when enabled
  function automatic logic [6:0] flt(input logic s, input logic o);
    return {3'h0, s | o, s, o, (s | o) & flag_en};
  endfunction

  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected outputs exp %b seen %b", exp, seen);
    end
  endtask

  task automatic note(input logic [6:0] v);
    notes.push_back(v);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // bounded wait on the bottom contact (sel 0) or the model busy flag (sel 1)
  task automatic wait_lvl(input logic sel, input logic v);
    repeat (400) begin
      @(posedge clock_i);
      if ((sel ? busy_c : bottom_c) === v) return;
    end
    err_total++;
    tally_and_finish();
  endtask

  // one stroke with a random gap; ups holds upstroke after each of the first two bottom rises and falls
  task automatic stroke(input logic [1:0] n, input logic [3:0] ups, input logic [6:0] fin);
    seed = lfsr_next(seed);
    gap <= seed[2:0];
    nb <= n;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (i < int'(n)) begin
        wait_lvl(1'b0, 1'b1);
        note({2'h3, ups[2*i], 4'h0});
        wait_lvl(1'b0, 1'b0);
        note({2'h3, ups[2*i+1], 4'h0});
      end
    end
    wait_lvl(1'b1, 1'b0);
    repeat (2) @(posedge clock_i);
    note(fin);
  endtask

  // configuration settles a cycle before the pulse, since it is read while timing
  task automatic clear_try(input logic en, input logic lng, input int len, input logic [6:0] exp);
    restart_en <= en;
    long_min <= lng;
    @(posedge clock_i);
    restart <= 1'b1;
    repeat (len) @(posedge clock_i);
    restart <= 1'b0;
    repeat (5) @(posedge clock_i);
    note(exp);
  endtask

  initial begin
    seed = lfsr_next(seed);
    flag_en = seed[0];
    repeat (5) @(posedge clock_i);
    note(7'h00);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    note(7'h40);
    for (int k = 0; k < 3; k++) begin
      stroke(2'h1, 4'h3, 7'h40);
    end
    stroke(2'h0, 4'h0, flt(1'b1, 1'b0));
    permit <= 1'b0;
    repeat (3) @(posedge clock_i);
    note(flt(1'b1, 1'b0));
    permit <= 1'b1;
    clear_try(1'b0, 1'b0, 20, flt(1'b1, 1'b0));
    clear_try(1'b1, 1'b0, 6, flt(1'b1, 1'b0));
    clear_try(1'b1, 1'b0, 48, flt(1'b1, 1'b0));
    clear_try(1'b1, 1'b1, 10, flt(1'b1, 1'b0));
    clear_try(1'b1, 1'b0, 10, 7'h40);
    permit <= 1'b0;
    repeat (3) @(posedge clock_i);
    note(7'h00);
    permit <= 1'b1;
    repeat (3) @(posedge clock_i);
    note(7'h40);
    multi <= 1'b1;
    stroke(2'h2, 4'h1, 7'h40);
    // stop while the bottom contact is made: after the return the spoilt cycle keeps upstroke low
    gap <= 3'h4;
    nb <= 2'h2;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    wait_lvl(1'b0, 1'b1);
    permit <= 1'b0;
    @(posedge clock_i);
    permit <= 1'b1;
    wait_lvl(1'b0, 1'b0);
    wait_lvl(1'b0, 1'b1);
    note(7'h60);
    wait_lvl(1'b1, 1'b0);
    repeat (2) @(posedge clock_i);
    note(7'h40);
    stroke(2'h0, 4'h0, 7'h40);
    stroke(2'h3, 4'h1, flt(1'b1, 1'b0));
    clear_try(1'b1, 1'b0, 20, 7'h40);
    drive <= 1'b0;
    stroke(2'h0, 4'h0, flt(1'b0, 1'b1));
    drive <= 1'b1;
    clear_try(1'b1, 1'b1, 20, 7'h40);
    ot_en <= 1'b0;
    drive <= 1'b0;
    stroke(2'h0, 4'h0, 7'h40);
    stroke(2'h2, 4'h1, 7'h40);
    tally_and_finish();
  end
endmodule
